/* File: hdl/cfg_params.svh */
// constants for the configure-parameter block
`ifndef CFG_PARAMS_SVH
`define CFG_PARAMS_SVH
`define CFG_MAX_BYTES 5'd22
`define CFG_CU_BYTES 5'd8
`define CFG_TX_WORDS_MAX 4'd7
`define CFG_RX_DEF 4'h8
`define CFG_IFS_RES 11'd8
`define CFG_BURST_RES 9'd4
`define CFG_BIT_TWCL 3
`define CFG_BIT_RDAL 2
`define CFG_BIT_MWI 0
`define CFG_BIT_DMBC 7
`define REG_CMD 4'h0
`define REG_CFG0 4'h1
`define REG_CFG1 4'h2
`define REG_STAT 4'h3
`define REG_DMA 4'h4
`endif

/* File: hdl/cfg_pkg.sv */
// types for the configure-parameter block
package cfg_pkg;
   typedef struct packed
   {
      logic [7:0] data;
      logic [4:0] index;
   } cfg_word_t;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_DONE = 3'b100
   } load_state_t;
endpackage : cfg_pkg

/* File: hdl/cfg_dma_params.sv */
// configure-command parameter logic with dma thresholds and arbitration limits
//
// Function
// - apply count leading bytes, max 22
// - bytes beyond eight forwarded to mac
// - tx bus request at tx fifo limit
// - tx limit n means 4n bytes
// - rx bus request at rx limit
// - small fifo: 64 minus 4n bytes
// - large fifo: 128 minus 8n bytes
// - frame gap at least 8 times value
// - terminate writes on cache line
// - align reads to cache line
// - mwi needs config and pci bits
// - rx burst capped at count times four
// - unlimited burst when nobody else requests
// - limiter disabled: rx never pre-empted
// - zero count yields almost at once
// - byte 5 bit 7 enables limiters; only the rx burst limiter exists here
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_params.svh"
module cfg_dma_params #(
   parameter int RX_FIFO_BYTES = 128
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // avalon-mm slave
   input wire logic [3:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // forwarded mac bytes
   output logic mac_valid_o,
   output logic [12:0] mac_word_o,
   input wire logic mac_ready_i,
   // fifo levels and dma status
   input wire logic [6:0] tx_fill_i,
   input wire logic [7:0] rx_fill_i,
   input wire logic pci_mwi_i,
   input wire logic frame_done_i,
   input wire logic rx_beat_i,
   input wire logic rx_active_i,
   input wire logic other_req_i,
   // controls
   output logic tx_bus_req_o,
   output logic rx_bus_req_o,
   output logic tx_hold_o,
   output logic term_write_cl_o,
   output logic read_align_o,
   output logic mwi_use_o,
   output logic rx_yield_o
);
   logic [7:0] cfg [0:7];
   logic [7:0] img [0:`CFG_MAX_BYTES-1];
   logic [4:0] count;
   logic [4:0] idx;
   cfg_pkg::load_state_t state;
   cfg_pkg::cfg_word_t buf0, buf1;
   cfg_pkg::cfg_word_t in_word;
   logic [1:0] occ;
   logic busy;
   logic [10:0] gap_cnt;
   logic [9:0] burst_cnt;
   logic [7:0] rx_thresh;
   logic [6:0] tx_thresh;
   logic [10:0] gap_min;
   logic [9:0] burst_max;
   logic push;
   logic pop;
   logic ack;

   // ----------------------------------------
   // avalon slave
   // ----------------------------------------
   assign ack = (read_i || write_i) && waitrequest_o;
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         waitrequest_o <= 1'b1;
      else
         waitrequest_o <= !ack;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         readdata_o <= 32'h0;
      else if (read_i && waitrequest_o)
      begin
         unique case (address_i)
            `REG_CFG0: readdata_o <= {cfg[3], cfg[2], cfg[1], cfg[0]};
            `REG_CFG1: readdata_o <= {cfg[7], cfg[6], cfg[5], cfg[4]};
            `REG_STAT: readdata_o <= {27'h0, busy, occ, rx_bus_req_o, tx_bus_req_o};
            default: readdata_o <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // configure image writes
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `CFG_MAX_BYTES; g++)
      begin : gen_img
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
               img[g] <= (g == 1) ? {4'h0, `CFG_RX_DEF} : 8'h00;
            else if (write_i && !waitrequest_o && address_i >= `REG_DMA
                     && (address_i - `REG_DMA) == 4'(g / 4))
               img[g] <= writedata_i[8 * (g % 4) +: 8];
         end
      end
   endgenerate

   // ----------------------------------------
   // load sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         state <= cfg_pkg::ST_IDLE;
         idx <= 5'h0;
         count <= 5'h0;
      end
      else
      begin
         unique case (state)
            cfg_pkg::ST_IDLE:
               if (write_i && !waitrequest_o && address_i == `REG_CMD)
               begin
                  // clamp count to 22
                  count <= (writedata_i[5:0] > 6'(`CFG_MAX_BYTES)) ? `CFG_MAX_BYTES
                           : writedata_i[4:0];
                  idx <= 5'h0;
                  state <= cfg_pkg::ST_LOAD;
               end
            cfg_pkg::ST_LOAD:
               if (idx >= count)
                  state <= cfg_pkg::ST_DONE;
               else if (idx < `CFG_CU_BYTES || occ != 2'd2)
                  idx <= idx + 5'h1;
            cfg_pkg::ST_DONE:
               state <= cfg_pkg::ST_IDLE;
            default:
               state <= cfg_pkg::ST_IDLE;
         endcase
      end
   end
   assign busy = state != cfg_pkg::ST_IDLE;

   // command unit keeps first eight bytes
   generate
      for (g = 0; g < 8; g++)
      begin : gen_cfg
         always_ff @(posedge core_clk_i)
         begin
            if (!rst_n_i)
               cfg[g] <= (g == 1) ? {4'h0, `CFG_RX_DEF} : 8'h00;
            else if (state == cfg_pkg::ST_LOAD && idx < count && idx == 5'(g))
               cfg[g] <= (g == 0) ? {2'b00, img[0][5:0]} : img[g];
         end
      end
   endgenerate

   // ----------------------------------------
   // two-entry buffer toward the mac
   // ----------------------------------------
   assign push = state == cfg_pkg::ST_LOAD && idx < count && idx >= `CFG_CU_BYTES
                 && occ != 2'd2;
   assign pop = mac_valid_o && mac_ready_i;
   assign in_word = '{data: img[idx], index: idx};
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         occ <= 2'd0;
         buf0 <= '0;
         buf1 <= '0;
      end
      else
      begin
         unique case ({push, pop})
            2'b10:
            begin
               if (occ == 2'd0)
                  buf0 <= '{data: img[idx], index: idx};
               else
                  buf1 <= '{data: img[idx], index: idx};
               occ <= occ + 2'd1;
            end
            2'b01:
            begin
               buf0 <= buf1;
               occ <= occ - 2'd1;
            end
            2'b11:
            begin
               if (occ == 2'd1)
                  buf0 <= '{data: img[idx], index: idx};
               else
               begin
                  buf0 <= buf1;
                  buf1 <= '{data: img[idx], index: idx};
               end
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         mac_valid_o <= 1'b0;
         mac_word_o <= 13'h0;
      end
      else
      begin
         mac_valid_o <= (occ != 2'd0 && !pop) || occ == 2'd2 || (push && occ != 2'd0)
                        || (push && !mac_valid_o);
         if (pop || !mac_valid_o)
         begin
            if (occ == 2'd2 || (occ == 2'd1 && !pop))
               mac_word_o <= (occ == 2'd1) ? buf0 : buf1;
            else if (push)
               mac_word_o <= in_word;
         end
      end
   end

   // ----------------------------------------
   // fifo thresholds
   // ----------------------------------------
   always_comb
   begin
      tx_thresh = {2'b00, cfg[1][6:4], 2'b00};
      if (RX_FIFO_BYTES == 64)
         rx_thresh = 8'd64 - {2'b00, cfg[1][3:0], 2'b00};
      else
         rx_thresh = 8'd128 - {1'b0, cfg[1][3:0], 3'b000};
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_bus_req_o <= 1'b0;
         rx_bus_req_o <= 1'b0;
      end
      else
      begin
         tx_bus_req_o <= tx_fill_i >= tx_thresh;
         rx_bus_req_o <= rx_fill_i >= rx_thresh;
      end
   end

   // ----------------------------------------
   // adaptive frame gap
   // ----------------------------------------
   assign gap_min = 11'(cfg[2]) * `CFG_IFS_RES;
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         gap_cnt <= 11'h0;
      else if (frame_done_i)
         gap_cnt <= 11'h0;
      else if (gap_cnt != 11'h7ff)
         gap_cnt <= gap_cnt + 11'h1;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         tx_hold_o <= 1'b0;
      else
         tx_hold_o <= frame_done_i ? (gap_min > 11'd1)
                      : ({1'b0, gap_cnt} + 12'd2 <= {1'b0, gap_min});
   end

   // ----------------------------------------
   // pci master options
   // ----------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         term_write_cl_o <= 1'b0;
         read_align_o <= 1'b0;
         mwi_use_o <= 1'b0;
      end
      else
      begin
         term_write_cl_o <= cfg[3][`CFG_BIT_TWCL];
         read_align_o <= cfg[3][`CFG_BIT_RDAL];
         mwi_use_o <= cfg[3][`CFG_BIT_MWI] && pci_mwi_i;
      end
   end

   // ----------------------------------------
   // receive burst limiter
   // ----------------------------------------
   assign burst_max = 10'(cfg[4][6:0]) * 10'(`CFG_BURST_RES);
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         burst_cnt <= 10'h0;
      else if (!rx_active_i)
         burst_cnt <= 10'h0;
      else if (rx_beat_i && burst_cnt != 10'h3ff)
         burst_cnt <= burst_cnt + 10'h1;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
         rx_yield_o <= 1'b0;
      else
         // enable bit no peer disabled zero
         rx_yield_o <= cfg[5][`CFG_BIT_DMBC] && other_req_i && rx_active_i
                       && burst_cnt >= burst_max;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_mwi_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      mwi_use_o |-> $past(pci_mwi_i))
      else $error("mwi used without pci enable");
   a_no_yield_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !cfg[5][`CFG_BIT_DMBC] ##1 !cfg[5][`CFG_BIT_DMBC] |-> !rx_yield_o)
      else $error("yield while limiter off");
   a_no_yield_alone: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      rx_yield_o |-> $past(other_req_i))
      else $error("yield with no other request");
   a_count_cap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      count <= `CFG_MAX_BYTES)
      else $error("count above limit");
   a_tx_thresh: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      tx_fill_i < {2'b00, cfg[1][6:4], 2'b00} |=> !tx_bus_req_o)
      else $error("tx request below limit");
   a_cu_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      mac_valid_o |-> mac_word_o[4:0] >= `CFG_CU_BYTES)
      else $error("cu byte sent to mac");
   a_rx_req: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (rx_fill_i >= rx_thresh) |=> rx_bus_req_o)
      else $error("rx request missing");
   a_tx_req: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (tx_fill_i >= tx_thresh) |=> tx_bus_req_o)
      else $error("tx request missing");
   c_load: cover property (@(posedge core_clk_i) state == cfg_pkg::ST_DONE);
   c_push: cover property (@(posedge core_clk_i) push && occ == 2'd1);
   c_yield: cover property (@(posedge core_clk_i) rx_yield_o);
endmodule : cfg_dma_params
`default_nettype wire

/* File: verif/mac_sink.sv */
// mac-side sink model taking forwarded configuration bytes
`timescale 1ns/100ps
`default_nettype none
module mac_sink (
   // clock
   input wire logic core_clk_i,
   // forwarded bytes
   input wire logic mac_valid_i,
   input wire logic [12:0] mac_word_i,
   output logic mac_ready_o = 1'b0,
   // observation
   output var int n_words_o = 0,
   output logic [12:0] first_word_o = '0,
   output logic [12:0] last_word_o = '0
);
   // ready every other cycle, so the sender must hold its word
   always @(posedge core_clk_i)
   begin
      mac_ready_o <= ~mac_ready_o;
      if (mac_valid_i && mac_ready_o)
      begin
         if (n_words_o == 0)
            first_word_o <= mac_word_i;
         last_word_o <= mac_word_i;
         n_words_o <= n_words_o + 1;
      end
   end
endmodule : mac_sink
`default_nettype wire

/* File: verif/cfg_dma_params_tb.sv */
// self-checking bench for the configure-parameter block
`timescale 1ns/100ps
`default_nettype none
`include "cfg_params.svh"
module cfg_dma_params_tb;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, ready, valid;
   logic [3:0] addr = '0;
   logic [31:0] wdata = '0, rdata, q;
   logic [12:0] word, first_w, last_w;
   logic [6:0] tx_fill = '0;
   logic [7:0] rx_fill = '0;
   logic mwi = 0, fdone = 0, beat = 0, ract = 0, oreq = 0, waitreq;
   logic txr, rxr, hold, twcl, ral, mwiu, yld;
   logic [7:0] img [22];
   int n_words, n_errors = 0, n_compared = 0;
   always #50 clk = ~clk;
   cfg_dma_params u_cfg_dma_params (.core_clk_i(clk), .rst_n_i(rst_n), .address_i(addr),
      .read_i(rd), .write_i(wr), .writedata_i(wdata), .readdata_o(rdata),
      .waitrequest_o(waitreq), .mac_valid_o(valid), .mac_word_o(word), .mac_ready_i(ready),
      .tx_fill_i(tx_fill), .rx_fill_i(rx_fill), .pci_mwi_i(mwi), .frame_done_i(fdone),
      .rx_beat_i(beat), .rx_active_i(ract), .other_req_i(oreq), .tx_bus_req_o(txr),
      .rx_bus_req_o(rxr), .tx_hold_o(hold), .term_write_cl_o(twcl), .read_align_o(ral),
      .mwi_use_o(mwiu), .rx_yield_o(yld));
   mac_sink u_mac_sink (.core_clk_i(clk), .mac_valid_i(valid), .mac_word_i(word),
      .mac_ready_o(ready), .n_words_o(n_words), .first_word_o(first_w),
      .last_word_o(last_w));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk); while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   // write the image, start a load, then poll busy
   task load(input logic [5:0] cnt);
      for (int k = 0; k < 6; k++)
         bus(1, 4'h4 + 4'(k), {img[(4*k+3)%22], img[(4*k+2)%22], img[4*k+1], img[4*k]});
      bus(1, `REG_CMD, {26'h0, cnt});
      for (int i = 0; i < 100; i++)
      begin
         bus(0, `REG_STAT, '0);
         if (q[4] === 1'b0)
            break;
      end
      cycles(40);
   endtask : load
   task beats(input int n);
      repeat (n)
      begin
         beat <= 1'b1;
         @(posedge clk);
      end
      beat <= 1'b0;
      cycles(2);
   endtask : beats
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      tally_and_finish;
   end
   initial
   begin
      cycles(5);
      rst_n <= 1'b1;
      bus(0, `REG_CFG0, '0);
      chk(q, 32'h0000_0800);
      bus(0, 4'hf, '0);
      chk(q, 32'h0);
      $display("reset test done");
      for (int i = 0; i < 22; i++)
         img[i] = 8'h40 + 8'(i);
      img[1] = 8'h3f;
      img[2] = 8'h01;
      img[3] = 8'h0d;
      img[4] = 8'h01;
      img[5] = 8'h80;
      load(6'h16);
      bus(0, `REG_CFG1, '0);
      chk(q, {img[7], img[6], img[5], img[4]});
      chk(n_words, 14);
      chk(first_w, {8'h48, 5'd8});
      chk(last_w, {8'h55, 5'd21});
      chk({twcl, ral, mwiu}, 3'b110);
      mwi <= 1'b1;
      tx_fill <= 7'd12;
      rx_fill <= 8'd7;
      cycles(3);
      chk({mwiu, txr, rxr}, 3'b110);
      rx_fill <= 8'd8;
      cycles(3);
      chk(rxr, 1);
      fdone <= 1'b1;
      @(posedge clk);
      fdone <= 1'b0;
      cycles(4);
      chk(hold, 1);
      cycles(10);
      chk(hold, 0);
      ract <= 1'b1;
      oreq <= 1'b1;
      beats(2);
      chk(yld, 0);
      beats(3);
      chk(yld, 1);
      oreq <= 1'b0;
      cycles(3);
      chk(yld, 0);
      ract <= 1'b0;
      cycles(2);
      $display("full load test done");
      img[1] = 8'h00;
      img[3] = 8'h00;
      img[5] = 8'h00;
      img[12] = 8'hff;
      load(6'h08);
      bus(0, `REG_CFG0, '0);
      chk(q[15:8], 8'h00);
      chk(n_words, 14);
      chk({twcl, ral, mwiu}, 3'b000);
      rx_fill <= 8'd127;
      cycles(3);
      chk(rxr, 0);
      rx_fill <= 8'd128;
      cycles(3);
      chk(rxr, 1);
      ract <= 1'b1;
      oreq <= 1'b1;
      beats(8);
      chk(yld, 0);
      img[4] = 8'h22;
      load(6'h04);
      bus(0, `REG_CFG1, '0);
      chk(q, 32'h4746_0001);
      $display("short load test done");
      tally_and_finish;
   end
endmodule : cfg_dma_params_tb
`default_nettype wire
